// ### bench/cao_core_monitor.sv
// Assertion checker for the addressing and execute core
`timescale 1ns/1ps
module cao_core_monitor (
    // Clock and control
    input wire logic mclk_in,
    input wire logic arst_n_in,
    input wire logic en_in,
    // Bus and state
    input wire logic [7:0] rdata_in,
    input wire cao_pkg::cao_bus_t bus_out,
    input wire logic [7:0] acc_out,
    input wire logic [15:0] idx_out,
    input wire logic [15:0] sp_out,
    input wire logic carry_out,
    input wire logic done_out
);
    logic go;
    assign go = done_out & en_in & bus_out.rd;
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!arst_n_in);
    property p_nop;
        go && rdata_in == 8'h9D |=> done_out && acc_out == $past(acc_out);
    endproperty
    a_nop: assert property (p_nop) else $error("idle op");
    property p_neg;
        go && rdata_in == 8'h40 |=> done_out && acc_out == 8'h00 - $past(acc_out);
    endproperty
    a_neg: assert property (p_neg) else $error("negate");
    property p_mul;
        go && rdata_in == 8'h42 |=> {idx_out[7:0], acc_out} ==
            $past(idx_out[7:0]) * $past(acc_out) ##4 done_out;
    endproperty
    a_mul: assert property (p_mul) else $error("product");
    property p_push;
        go && rdata_in == 8'h87 |=> bus_out.wr && bus_out.wdata == $past(acc_out)
            && bus_out.addr == $past(sp_out) && sp_out == $past(sp_out) - 16'h0001
            ##1 done_out;
    endproperty
    a_push: assert property (p_push) else $error("push");
    property p_pull;
        go && rdata_in == 8'h86 |=> bus_out.rd && bus_out.addr == sp_out
            && sp_out == $past(sp_out) + 16'h0001
            ##2 done_out && acc_out == $past(rdata_in, 2);
    endproperty
    a_pull: assert property (p_pull) else $error("pull");
    property p_ora;
        go && rdata_in == 8'hBA |=> bus_out.rd ##1 bus_out.rd
            && bus_out.addr == {8'h00, $past(rdata_in)}
            ##1 done_out && acc_out == ($past(acc_out, 2) | $past(rdata_in));
    endproperty
    a_ora: assert property (p_ora) else $error("zero page or");
    property p_rol;
        go && rdata_in == 8'h49 |=> done_out
            && {carry_out, acc_out} == {$past(acc_out), $past(carry_out)};
    endproperty
    a_rol: assert property (p_rol) else $error("rotate left");
    property p_ror;
        go && rdata_in == 8'h46 |=> done_out
            && {acc_out, carry_out} == {$past(carry_out), $past(acc_out)};
    endproperty
    a_ror: assert property (p_ror) else $error("rotate right");
endmodule // cao_core_monitor
bind cao_core cao_core_monitor cao_core_monitor_i (.mclk_in, .arst_n_in,
    .en_in, .rdata_in, .bus_out, .acc_out, .idx_out, .sp_out, .carry_out,
    .done_out);

// ### bench/cao_core_tb_top.sv
// Self-checking bench for the addressing and execute core
`timescale 1ns/1ps
module cao_core_tb_top;
    logic mclk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic en_in = 1'b0;
    logic [7:0] rdata_in, acc_out;
    cao_pkg::cao_bus_t bus_out;
    logic [15:0] idx_out, sp_out, pc_out;
    logic carry_out, done_out, bad_op_out;
    logic [7:0] q[$];
    int err_count = 0;
    int total_checks = 0;
    int cyc;
    always #25 mclk_in = ~mclk_in;
    cao_core cao_core_i (.mclk_in, .arst_n_in, .en_in, .rdata_in, .bus_out,
        .acc_out, .idx_out, .sp_out, .pc_out, .carry_out, .done_out,
        .bad_op_out);
    cao_mem_model cao_mem_model_i (.mclk_in, .bus_in(bus_out),
        .rdata_out(rdata_in));
    task automatic cmp(input logic [15:0] got, exp, input string what);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic chk_mem(input logic [15:0] a, input logic [7:0] e);
        cmp({8'h00, cao_mem_model_i.mem[a]}, {8'h00, e}, "mem");
    endtask
    task automatic poke(input logic [15:0] a, input logic [7:0] d);
        cao_mem_model_i.mem[a] = d;
    endtask
    // Load code at pc, run n instructions, count cycles
    task automatic run(input int n);
        int k;
        k = 0;
        cyc = 0;
        @(negedge mclk_in);
        foreach (q[i]) poke(pc_out + 16'(i), q[i]);
        en_in = 1'b1;
        while (k < n && cyc < 200) begin
            @(negedge mclk_in);
            cyc++;
            if (done_out === 1'b1) k++;
        end
        en_in = 1'b0;
        if (k < n) begin
            err_count++;
            $display("Error %0t run limit", $time);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic t_stack();
        poke(16'h0100, 8'h90);
        poke(16'h0101, 8'hB7);
        poke(16'h0102, 8'h4C);
        q = '{8'h88, 8'h86, 8'h8A, 8'h87, 8'h8B, 8'h89};
        run(6);
        cmp(16'(cyc), 16'd15, "stack cycles");
        cmp(idx_out, 16'h4C90, "index");
        chk_mem(16'h0101, 8'h4C);
        cmp(sp_out, 16'h00FF, "sp");
        chk_mem(16'h0102, 8'hB7);
        $display("test stack done");
    endtask
    task automatic t_move();
        poke(16'h0080, 8'h5A);
        poke(16'h4C91, 8'h3C);
        q = '{8'h4E, 8'h80, 8'h81, 8'h6E, 8'hC3, 8'h82, 8'h5E, 8'h80,
            8'h7E, 8'h83};
        run(4);
        cmp(16'(cyc), 16'd19, "move cycles");
        chk_mem(16'h0081, 8'h5A);
        chk_mem(16'h0082, 8'hC3);
        chk_mem(16'h4C90, 8'h5A);
        chk_mem(16'h0083, 8'h3C);
        cmp(idx_out, 16'h4C92, "post increment");
        $display("test move done");
    endtask
    task automatic t_alu();
        poke(16'h0084, 8'h20);
        q = '{8'hAA, 8'h48, 8'h40, 8'hBA, 8'h84, 8'h62, 8'h42, 8'h50, 8'h9D};
        run(7);
        cmp(16'(cyc), 16'd14, "alu cycles");
        cmp(acc_out, 16'h0044, "acc");
        cmp(idx_out, 16'h4CF6, "index");
        $display("test alu done");
    endtask
    task automatic t_rot();
        q = '{8'h49, 8'h49, 8'h46, 8'h59, 8'h36, 8'h81, 8'h39, 8'h80, 8'h56};
        run(7);
        cmp(16'(cyc), 16'd15, "rotate cycles");
        cmp(acc_out, 16'h0088, "acc");
        cmp(idx_out, 16'h4C76, "index");
        cmp(16'(carry_out), 16'h0000, "carry");
        chk_mem(16'h0081, 8'hAD);
        chk_mem(16'h0080, 8'hB4);
        $display("test rotate done");
    endtask
    task automatic t_modes();
        poke(16'h4C76, 8'h02);
        poke(16'h4C86, 8'h20);
        poke(16'h0085, 8'h04);
        q = '{8'h30, 8'h84, 8'h9E, 8'hEA, 8'h01, 8'h9E, 8'h60, 8'h03,
            8'h9E, 8'hDA, 8'h00, 8'h03, 8'hFA, 8'hEA, 8'h10,
            8'hCA, 8'h00, 8'h85};
        run(7);
        cmp(16'(cyc), 16'd30, "modes cycles");
        chk_mem(16'h0084, 8'hE0);
        chk_mem(16'h0102, 8'h49);
        cmp(acc_out, 16'h00FF, "acc");
        $display("test modes done");
    endtask
    task automatic t_index();
        q = '{8'h40, 8'h60, 8'h0A, 8'h70, 8'h69, 8'h10, 8'h79, 8'h66,
            8'h10, 8'h76, 8'h9E, 8'h69, 8'h01, 8'h9E, 8'h66, 8'h02,
            8'hDA, 8'h00, 8'h10, 8'h9E, 8'h9D, 8'h00};
        run(12);
        cmp(16'(cyc), 16'd47, "index cycles");
        chk_mem(16'h4C80, 8'h63);
        chk_mem(16'h4C76, 8'h7E);
        chk_mem(16'h4C86, 8'hA0);
        chk_mem(16'h0100, 8'h20);
        chk_mem(16'h0101, 8'hA6);
        cmp(acc_out, 16'h00A1, "acc");
        cmp(16'(bad_op_out), 16'h0001, "bad op");
        cmp(pc_out, 16'h004A, "pc");
        $display("test index done");
    endtask
    initial begin
        for (int a = 0; a < 65536; a++) poke(16'(a), 8'h9D);
        repeat (16) @(negedge mclk_in);
        arst_n_in = 1'b1;
        @(negedge mclk_in);
        cmp(sp_out, 16'h00FF, "reset sp");
        t_stack();
        t_move();
        t_alu();
        t_rot();
        t_modes();
        t_index();
        report_and_stop();
    end
    initial begin
        #(50 * 3000);
        err_count++;
        report_and_stop();
    end
endmodule // cao_core_tb_top

// ### bench/cao_mem_model.sv
// Zero-wait byte memory on the core bus
`timescale 1ns/1ps
module cao_mem_model (
    // Clock and bus
    input wire logic mclk_in,
    input wire cao_pkg::cao_bus_t bus_in,
    // Read data
    output logic [7:0] rdata_out
);
    logic [7:0] mem [0:65535];
    logic [7:0] last_ff = 8'h00;
    assign rdata_out = bus_in.rd ? mem[bus_in.addr] : ~last_ff;
    always @(posedge mclk_in) begin
        last_ff <= rdata_out;
        if (bus_in.wr)
            mem[bus_in.addr] <= bus_in.wdata;
    end
endmodule // cao_mem_model

// ### verilog/cao_core.sv
// Operand address generation and execute for a subset of the 8-bit core
// Functional notes
// - Zero-page address is 0x00 above the one address byte fetched.
// - Full-address mode fetches two address bytes, upper byte first.
// - Seven indexed forms: five on the index pair, two on SP.
// - Plain index uses the pair; byte offset adds unsigned byte.
// - Post-increment index uses pair, then pair plus one; move only here.
// - Byte-offset post-increment is compare-branch only; not built here.
// - Moves 4E,5E,6E,7E copy source to destination; index forms bump pair.
// - Opcode 42 multiplies X by A unsigned into X:A in 5 cycles.
// - Negate 30 (5 cycles), 40 and 50 (1 cycle) give 0x00 minus operand.
// - Opcode 9D does nothing for exactly one cycle.
// - Opcode 62 swaps accumulator nibbles in one cycle.
// - OR into accumulator: AA immediate 2 cycles, BA zero-page 3.
// - Stack-relative forms are 9E prefix then the index-form opcode.
// - Push 87, 8B, 89 store at SP then decrement, 2 cycles.
// - Pull 86, 8A, 88 increment SP then load, 3 cycles.
// - Rotate left 39 (5 cycles), 49, 59 (1 cycle) through carry.
// - Rotate right 36 (5 cycles), 46, 56 (1 cycle) through carry.
`timescale 1ns/1ps
`include "cao_map.svh"
module cao_core (
    // Clock, reset, enable
    input wire logic mclk_in,
    input wire logic arst_n_in,
    input wire logic en_in,
    // Memory bus
    input wire logic [7:0] rdata_in,
    output cao_pkg::cao_bus_t bus_out,
    // Core state
    output logic [7:0] acc_out,
    output logic [15:0] idx_out,
    output logic [15:0] sp_out,
    output logic [15:0] pc_out,
    output logic carry_out,
    output logic done_out,
    output logic bad_op_out
);
    cao_pkg::cao_state_t state_ff, nxt_state;
    cao_pkg::cao_dec_t dec_ff, nxt_dec;
    cao_pkg::cao_bus_t bus_ff, nxt_bus;
    logic pre_ff, nxt_pre;
    logic [3:0] cnt_ff, nxt_cnt;
    logic [15:0] pc_ff, nxt_pc;
    logic [15:0] ea_ff, nxt_ea;
    logic [7:0] t1_ff, nxt_t1;
    logic [7:0] dat_ff, nxt_dat;
    logic [7:0] acc_ff, nxt_acc;
    logic [15:0] hx_ff, nxt_hx;
    logic [15:0] sp_ff, nxt_sp;
    logic c_ff, nxt_c;
    logic done_ff, nxt_done;
    logic bad_ff, nxt_bad;
    logic finish;

    function automatic cao_pkg::cao_dec_t mk(input cao_pkg::cao_cls_t c,
        input cao_pkg::cao_mode_t m, input cao_pkg::cao_reg_t s,
        input logic [3:0] n);
        mk.cls = c;
        mk.mode = m;
        mk.sel = s;
        mk.cyc = n;
    endfunction

    // Opcode to class, mode, register and bus-cycle count
    function automatic cao_pkg::cao_dec_t decode(input logic pre,
        input logic [7:0] op);
        decode = mk(cao_pkg::C_BAD, cao_pkg::M_INH, cao_pkg::R_A, `CAO_CYC_1);
        if (pre) begin
            case (op)
                `CAO_OP_NEG_IX1: decode = mk(cao_pkg::C_NEG, cao_pkg::M_SP1,
                    cao_pkg::R_A, `CAO_CYC_6);
                `CAO_OP_ROL_IX1: decode = mk(cao_pkg::C_ROL, cao_pkg::M_SP1,
                    cao_pkg::R_A, `CAO_CYC_6);
                `CAO_OP_ROR_IX1: decode = mk(cao_pkg::C_ROR, cao_pkg::M_SP1,
                    cao_pkg::R_A, `CAO_CYC_6);
                `CAO_OP_ORA_IX2: decode = mk(cao_pkg::C_ORA, cao_pkg::M_SP2,
                    cao_pkg::R_A, `CAO_CYC_5);
                `CAO_OP_ORA_IX1: decode = mk(cao_pkg::C_ORA, cao_pkg::M_SP1,
                    cao_pkg::R_A, `CAO_CYC_4);
                default: decode.cyc = `CAO_CYC_2;
            endcase
        end else begin
            case (op)
                `CAO_OP_MOV_DD: decode = mk(cao_pkg::C_MDD, cao_pkg::M_DIR,
                    cao_pkg::R_A, `CAO_CYC_5);
                `CAO_OP_MOV_DX: decode = mk(cao_pkg::C_MDX, cao_pkg::M_DIR,
                    cao_pkg::R_A, `CAO_CYC_5);
                `CAO_OP_MOV_ID: decode = mk(cao_pkg::C_MID, cao_pkg::M_IMM,
                    cao_pkg::R_A, `CAO_CYC_4);
                `CAO_OP_MOV_XD: decode = mk(cao_pkg::C_MXD, cao_pkg::M_DIR,
                    cao_pkg::R_A, `CAO_CYC_5);
                `CAO_OP_MUL: decode = mk(cao_pkg::C_MUL, cao_pkg::M_INH,
                    cao_pkg::R_A, `CAO_CYC_5);
                `CAO_OP_NEG_DIR: decode = mk(cao_pkg::C_NEG, cao_pkg::M_DIR,
                    cao_pkg::R_A, `CAO_CYC_5);
                `CAO_OP_NEG_A: decode = mk(cao_pkg::C_NEG, cao_pkg::M_INH,
                    cao_pkg::R_A, `CAO_CYC_1);
                `CAO_OP_NEG_X: decode = mk(cao_pkg::C_NEG, cao_pkg::M_INH,
                    cao_pkg::R_X, `CAO_CYC_1);
                `CAO_OP_NEG_IX1: decode = mk(cao_pkg::C_NEG, cao_pkg::M_IX1,
                    cao_pkg::R_A, `CAO_CYC_5);
                `CAO_OP_NEG_IX: decode = mk(cao_pkg::C_NEG, cao_pkg::M_IX,
                    cao_pkg::R_A, `CAO_CYC_4);
                `CAO_OP_NOP: decode = mk(cao_pkg::C_NOP, cao_pkg::M_INH,
                    cao_pkg::R_A, `CAO_CYC_1);
                `CAO_OP_NSA: decode = mk(cao_pkg::C_NSA, cao_pkg::M_INH,
                    cao_pkg::R_A, `CAO_CYC_1);
                `CAO_OP_ORA_IMM: decode = mk(cao_pkg::C_ORA, cao_pkg::M_IMM,
                    cao_pkg::R_A, `CAO_CYC_2);
                `CAO_OP_ORA_DIR: decode = mk(cao_pkg::C_ORA, cao_pkg::M_DIR,
                    cao_pkg::R_A, `CAO_CYC_3);
                `CAO_OP_ORA_EXT: decode = mk(cao_pkg::C_ORA, cao_pkg::M_EXT,
                    cao_pkg::R_A, `CAO_CYC_4);
                `CAO_OP_ORA_IX2: decode = mk(cao_pkg::C_ORA, cao_pkg::M_IX2,
                    cao_pkg::R_A, `CAO_CYC_4);
                `CAO_OP_ORA_IX1: decode = mk(cao_pkg::C_ORA, cao_pkg::M_IX1,
                    cao_pkg::R_A, `CAO_CYC_3);
                `CAO_OP_ORA_IX: decode = mk(cao_pkg::C_ORA, cao_pkg::M_IX,
                    cao_pkg::R_A, `CAO_CYC_3);
                `CAO_OP_PSH_A: decode = mk(cao_pkg::C_PSH, cao_pkg::M_INH,
                    cao_pkg::R_A, `CAO_CYC_2);
                `CAO_OP_PSH_H: decode = mk(cao_pkg::C_PSH, cao_pkg::M_INH,
                    cao_pkg::R_H, `CAO_CYC_2);
                `CAO_OP_PSH_X: decode = mk(cao_pkg::C_PSH, cao_pkg::M_INH,
                    cao_pkg::R_X, `CAO_CYC_2);
                `CAO_OP_PUL_A: decode = mk(cao_pkg::C_PUL, cao_pkg::M_INH,
                    cao_pkg::R_A, `CAO_CYC_3);
                `CAO_OP_PUL_H: decode = mk(cao_pkg::C_PUL, cao_pkg::M_INH,
                    cao_pkg::R_H, `CAO_CYC_3);
                `CAO_OP_PUL_X: decode = mk(cao_pkg::C_PUL, cao_pkg::M_INH,
                    cao_pkg::R_X, `CAO_CYC_3);
                `CAO_OP_ROL_DIR: decode = mk(cao_pkg::C_ROL, cao_pkg::M_DIR,
                    cao_pkg::R_A, `CAO_CYC_5);
                `CAO_OP_ROL_A: decode = mk(cao_pkg::C_ROL, cao_pkg::M_INH,
                    cao_pkg::R_A, `CAO_CYC_1);
                `CAO_OP_ROL_X: decode = mk(cao_pkg::C_ROL, cao_pkg::M_INH,
                    cao_pkg::R_X, `CAO_CYC_1);
                `CAO_OP_ROL_IX1: decode = mk(cao_pkg::C_ROL, cao_pkg::M_IX1,
                    cao_pkg::R_A, `CAO_CYC_5);
                `CAO_OP_ROL_IX: decode = mk(cao_pkg::C_ROL, cao_pkg::M_IX,
                    cao_pkg::R_A, `CAO_CYC_4);
                `CAO_OP_ROR_DIR: decode = mk(cao_pkg::C_ROR, cao_pkg::M_DIR,
                    cao_pkg::R_A, `CAO_CYC_5);
                `CAO_OP_ROR_A: decode = mk(cao_pkg::C_ROR, cao_pkg::M_INH,
                    cao_pkg::R_A, `CAO_CYC_1);
                `CAO_OP_ROR_X: decode = mk(cao_pkg::C_ROR, cao_pkg::M_INH,
                    cao_pkg::R_X, `CAO_CYC_1);
                `CAO_OP_ROR_IX1: decode = mk(cao_pkg::C_ROR, cao_pkg::M_IX1,
                    cao_pkg::R_A, `CAO_CYC_5);
                `CAO_OP_ROR_IX: decode = mk(cao_pkg::C_ROR, cao_pkg::M_IX,
                    cao_pkg::R_A, `CAO_CYC_4);
                default: ;
            endcase
        end
    endfunction

    // Read-modify-write result, carry in bit 8
    function automatic logic [8:0] alu(input cao_pkg::cao_cls_t cls,
        input logic [7:0] v, input logic c);
        case (cls)
            cao_pkg::C_NEG: alu = {c, 8'h00 - v};
            cao_pkg::C_ROL: alu = {v[7], v[6:0], c};
            cao_pkg::C_ROR: alu = {v[0], c, v[7:1]};
            default: alu = {c, v};
        endcase
    endfunction

    wire cao_pkg::cao_dec_t dec_w = decode(pre_ff, rdata_in);
    wire [7:0] sel_w = (dec_w.sel == cao_pkg::R_A) ? acc_ff :
        (dec_w.sel == cao_pkg::R_H) ? hx_ff[15:8] : hx_ff[7:0];
    wire [8:0] inh_w = alu(dec_w.cls, sel_w, c_ff);
    wire [8:0] mem_w = alu(dec_ff.cls, rdata_in, c_ff);
    wire [15:0] prod_w = {8'h00, hx_ff[7:0]} * {8'h00, acc_ff};
    wire [15:0] off2_w = {t1_ff, rdata_in};
    wire [15:0] off1_w = {8'h00, rdata_in};
    wire [15:0] zp_w = {`CAO_ZP_HIGH, rdata_in};
    wire [15:0] hx_inc_w = hx_ff + 16'h0001;

    always_comb begin
        nxt_state = state_ff;
        nxt_pre = pre_ff;
        nxt_dec = dec_ff;
        nxt_cnt = (cnt_ff != 4'h0) ? cnt_ff - 4'h1 : 4'h0;
        nxt_pc = pc_ff;
        nxt_ea = ea_ff;
        nxt_t1 = t1_ff;
        nxt_dat = dat_ff;
        nxt_acc = acc_ff;
        nxt_hx = hx_ff;
        nxt_sp = sp_ff;
        nxt_c = c_ff;
        nxt_bus = '0;
        nxt_done = 1'b0;
        nxt_bad = 1'b0;
        finish = 1'b0;
        case (state_ff)
            cao_pkg::S_OPC: begin
                nxt_pc = pc_ff + 16'h0001;
                if (!pre_ff && rdata_in == `CAO_OP_PREFIX) begin
                    nxt_pre = 1'b1;
                    nxt_bus.addr = nxt_pc;
                    nxt_bus.rd = 1'b1;
                end else begin
                    nxt_pre = 1'b0;
                    nxt_dec = dec_w;
                    nxt_cnt = dec_w.cyc - (pre_ff ? 4'h2 : 4'h1);
                    if (dec_w.mode == cao_pkg::M_INH) begin
                        finish = 1'b1;
                        case (dec_w.cls)
                            cao_pkg::C_BAD: nxt_bad = 1'b1;
                            cao_pkg::C_MUL: begin
                                nxt_hx[7:0] = prod_w[15:8];
                                nxt_acc = prod_w[7:0];
                            end
                            cao_pkg::C_NSA:
                                nxt_acc = {acc_ff[3:0], acc_ff[7:4]};
                            cao_pkg::C_NEG, cao_pkg::C_ROL, cao_pkg::C_ROR: begin
                                nxt_c = inh_w[8];
                                if (dec_w.sel == cao_pkg::R_X)
                                    nxt_hx[7:0] = inh_w[7:0];
                                else
                                    nxt_acc = inh_w[7:0];
                            end
                            cao_pkg::C_PSH: begin
                                finish = 1'b0;
                                nxt_state = cao_pkg::S_WR;
                                nxt_bus.addr = sp_ff;
                                nxt_bus.wdata = sel_w;
                                nxt_bus.wr = 1'b1;
                                nxt_sp = sp_ff - 16'h0001;
                            end
                            cao_pkg::C_PUL: begin
                                finish = 1'b0;
                                nxt_sp = sp_ff + 16'h0001;
                                nxt_state = cao_pkg::S_RD;
                                nxt_bus.addr = nxt_sp;
                                nxt_bus.rd = 1'b1;
                            end
                            default: ;
                        endcase
                    end else if (dec_w.mode == cao_pkg::M_IX) begin
                        nxt_state = cao_pkg::S_RD;
                        nxt_ea = hx_ff;
                        nxt_bus.addr = hx_ff;
                        nxt_bus.rd = 1'b1;
                    end else begin
                        nxt_state = cao_pkg::S_B1;
                        nxt_bus.addr = nxt_pc;
                        nxt_bus.rd = 1'b1;
                    end
                end
            end
            cao_pkg::S_B1: begin
                nxt_pc = pc_ff + 16'h0001;
                nxt_t1 = rdata_in;
                nxt_bus.rd = 1'b1;
                nxt_state = cao_pkg::S_RD;
                case (dec_ff.mode)
                    cao_pkg::M_IMM: begin
                        if (dec_ff.cls == cao_pkg::C_ORA) begin
                            nxt_acc = acc_ff | rdata_in;
                            nxt_bus.rd = 1'b0;
                            finish = 1'b1;
                        end else begin
                            nxt_dat = rdata_in;
                            nxt_state = cao_pkg::S_B3;
                            nxt_bus.addr = nxt_pc;
                        end
                    end
                    cao_pkg::M_DIR: begin
                        nxt_ea = (dec_ff.cls == cao_pkg::C_MXD) ? hx_ff : zp_w;
                        nxt_bus.addr = nxt_ea;
                    end
                    cao_pkg::M_IX1: begin
                        nxt_ea = hx_ff + off1_w;
                        nxt_bus.addr = nxt_ea;
                    end
                    cao_pkg::M_SP1: begin
                        nxt_ea = sp_ff + off1_w;
                        nxt_bus.addr = nxt_ea;
                    end
                    default: begin
                        nxt_state = cao_pkg::S_B2;
                        nxt_bus.addr = nxt_pc;
                    end
                endcase
            end
            cao_pkg::S_B2: begin
                nxt_pc = pc_ff + 16'h0001;
                case (dec_ff.mode)
                    cao_pkg::M_IX2: nxt_ea = hx_ff + off2_w;
                    cao_pkg::M_SP2: nxt_ea = sp_ff + off2_w;
                    default: nxt_ea = off2_w;
                endcase
                nxt_state = cao_pkg::S_RD;
                nxt_bus.addr = nxt_ea;
                nxt_bus.rd = 1'b1;
            end
            cao_pkg::S_RD: begin
                nxt_state = cao_pkg::S_WR;
                nxt_bus.wr = 1'b1;
                nxt_bus.wdata = rdata_in;
                case (dec_ff.cls)
                    cao_pkg::C_ORA: begin
                        nxt_acc = acc_ff | rdata_in;
                        nxt_bus.wr = 1'b0;
                        finish = 1'b1;
                    end
                    cao_pkg::C_PUL: begin
                        nxt_bus.wr = 1'b0;
                        finish = 1'b1;
                        case (dec_ff.sel)
                            cao_pkg::R_H: nxt_hx[15:8] = rdata_in;
                            cao_pkg::R_X: nxt_hx[7:0] = rdata_in;
                            default: nxt_acc = rdata_in;
                        endcase
                    end
                    cao_pkg::C_MDD: begin
                        nxt_dat = rdata_in;
                        nxt_state = cao_pkg::S_B3;
                        nxt_bus.wr = 1'b0;
                        nxt_bus.rd = 1'b1;
                        nxt_bus.addr = pc_ff;
                    end
                    cao_pkg::C_MDX: begin
                        nxt_bus.addr = hx_ff;
                        nxt_hx = hx_inc_w;
                    end
                    cao_pkg::C_MXD: begin
                        nxt_hx = hx_inc_w;
                        nxt_bus.addr = {`CAO_ZP_HIGH, t1_ff};
                    end
                    default: begin
                        nxt_c = mem_w[8];
                        nxt_bus.addr = ea_ff;
                        nxt_bus.wdata = mem_w[7:0];
                    end
                endcase
            end
            cao_pkg::S_B3: begin
                nxt_pc = pc_ff + 16'h0001;
                nxt_state = cao_pkg::S_WR;
                nxt_bus.addr = zp_w;
                nxt_bus.wdata = dat_ff;
                nxt_bus.wr = 1'b1;
            end
            cao_pkg::S_WR: finish = 1'b1;
            cao_pkg::S_PAD: finish = 1'b1;
            default: finish = 1'b1;
        endcase
        if (finish) begin
            nxt_bus = '0;
            if (nxt_cnt == 4'h0) begin
                nxt_state = cao_pkg::S_OPC;
                nxt_done = 1'b1;
                nxt_bus.addr = nxt_pc;
                nxt_bus.rd = 1'b1;
            end else begin
                nxt_state = cao_pkg::S_PAD;
            end
        end
    end

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_ff <= cao_pkg::S_OPC;
            dec_ff <= '0;
            bus_ff <= '{addr: `CAO_PC_RST, wdata: 8'h00, rd: 1'b1, wr: 1'b0};
            {pre_ff, cnt_ff, ea_ff, t1_ff, dat_ff} <= '0;
            {acc_ff, hx_ff, c_ff, done_ff, bad_ff} <= '0;
            pc_ff <= `CAO_PC_RST;
            sp_ff <= `CAO_SP_RST;
        end else if (en_in) begin
            state_ff <= nxt_state;
            dec_ff <= nxt_dec;
            bus_ff <= nxt_bus;
            {pre_ff, cnt_ff, ea_ff, t1_ff, dat_ff} <=
                {nxt_pre, nxt_cnt, nxt_ea, nxt_t1, nxt_dat};
            {acc_ff, hx_ff, c_ff, done_ff, bad_ff} <=
                {nxt_acc, nxt_hx, nxt_c, nxt_done, nxt_bad};
            pc_ff <= nxt_pc;
            sp_ff <= nxt_sp;
        end
    end

    assign bus_out = bus_ff;
    assign acc_out = acc_ff;
    assign idx_out = hx_ff;
    assign sp_out = sp_ff;
    assign pc_out = pc_ff;
    assign carry_out = c_ff;
    assign done_out = done_ff;
    assign bad_op_out = bad_ff;
endmodule // cao_core

// ### verilog/cao_map.svh
// Opcodes, cycle counts and reset values of the addressing and execute core
`ifndef CAO_MAP_SVH
`define CAO_MAP_SVH
`define CAO_OP_PREFIX 8'h9E
`define CAO_OP_MOV_DD 8'h4E
`define CAO_OP_MOV_DX 8'h5E
`define CAO_OP_MOV_ID 8'h6E
`define CAO_OP_MOV_XD 8'h7E
`define CAO_OP_MUL 8'h42
`define CAO_OP_NEG_DIR 8'h30
`define CAO_OP_NEG_A 8'h40
`define CAO_OP_NEG_X 8'h50
`define CAO_OP_NEG_IX1 8'h60
`define CAO_OP_NEG_IX 8'h70
`define CAO_OP_NOP 8'h9D
`define CAO_OP_NSA 8'h62
`define CAO_OP_ORA_IMM 8'hAA
`define CAO_OP_ORA_DIR 8'hBA
`define CAO_OP_ORA_EXT 8'hCA
`define CAO_OP_ORA_IX2 8'hDA
`define CAO_OP_ORA_IX1 8'hEA
`define CAO_OP_ORA_IX 8'hFA
`define CAO_OP_PSH_A 8'h87
`define CAO_OP_PSH_H 8'h8B
`define CAO_OP_PSH_X 8'h89
`define CAO_OP_PUL_A 8'h86
`define CAO_OP_PUL_H 8'h8A
`define CAO_OP_PUL_X 8'h88
`define CAO_OP_ROL_DIR 8'h39
`define CAO_OP_ROL_A 8'h49
`define CAO_OP_ROL_X 8'h59
`define CAO_OP_ROL_IX1 8'h69
`define CAO_OP_ROL_IX 8'h79
`define CAO_OP_ROR_DIR 8'h36
`define CAO_OP_ROR_A 8'h46
`define CAO_OP_ROR_X 8'h56
`define CAO_OP_ROR_IX1 8'h66
`define CAO_OP_ROR_IX 8'h76
`define CAO_CYC_1 4'h1
`define CAO_CYC_2 4'h2
`define CAO_CYC_3 4'h3
`define CAO_CYC_4 4'h4
`define CAO_CYC_5 4'h5
`define CAO_CYC_6 4'h6
`define CAO_PC_RST 16'h0000
`define CAO_SP_RST 16'h00FF
`define CAO_ZP_HIGH 8'h00
`endif

// ### verilog/cao_pkg.sv
// Types shared by the addressing and execute core
package cao_pkg;
    typedef enum logic [3:0] {
        C_BAD, C_NOP, C_MUL, C_NSA, C_NEG, C_ROL, C_ROR, C_ORA,
        C_PSH, C_PUL, C_MDD, C_MDX, C_MID, C_MXD
    } cao_cls_t;
    typedef enum logic [3:0] {
        M_INH, M_IMM, M_DIR, M_EXT, M_IX, M_IX1, M_IX2, M_SP1, M_SP2
    } cao_mode_t;
    typedef enum logic [1:0] {R_A, R_H, R_X} cao_reg_t;
    typedef enum logic [2:0] {
        S_OPC, S_B1, S_B2, S_RD, S_B3, S_WR, S_PAD
    } cao_state_t;
    typedef struct packed {
        cao_cls_t cls;
        cao_mode_t mode;
        cao_reg_t sel;
        logic [3:0] cyc;
    } cao_dec_t;
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic rd;
        logic wr;
    } cao_bus_t;
endpackage
